// ==== hw/cbim_top.sv ====
/*
 Identifier section of one CAN message buffer: four byte registers,
 a control and a status register, the arbitration field sender and the
 receive store. Assumes a protocol engine on the same clock delivering
 received headers, and the CAN bus level arriving asynchronously.
*/
`timescale 1ns/1ps
`include "cbim_cfg.svh"
module cbim_top
   import cbim_pkg::*;
(
   input wire logic i_clock, // 10 MHz
   input wire logic i_rst_n, // async reset, low
   input wire logic [2:0] i_addr, // register offset
   input wire logic [7:0] i_wdata, // write data
   input wire logic i_wr, // write strobe
   input wire logic i_rd, // read strobe
   input wire cbim_rx_hdr_t i_rx, // received header
   input wire logic i_bus_bit, // bus level, async
   output logic [7:0] o_rdata, // read data, next cycle
   output logic o_tx_bit, // arbitration bit out
   output logic o_tx_active, // sending
   output logic o_tx_done, // field sent, pulse
   output logic o_lost, // arbitration lost, pulse
   output logic [28:0] o_prio_key // smaller wins
);
   logic rst_a;
   logic rst_q;
   logic s1;
   logic s2;
   logic s3;
   logic bus_lvl;
   logic tx_mode;
   logic lost_f;
   logic done_f;
   logic rx_new;
   logic [3:0] div;
   logic [4:0] cnt;
   logic [4:0] last;
   logic [31:0] sh;
   cbim_state_t state;
   cbim_state_t next_state;
   logic [7:0] idb [0:3];
   logic [7:0] rx_val [0:3];
   logic [7:0] next_rdata;
   logic [7:0] stat_byte;

   // reset release through two flops
   always_ff @(posedge i_clock or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rst_a <= 1'b0;
         rst_q <= 1'b0;
      end
      else
      begin
         rst_a <= 1'b1;
         rst_q <= rst_a;
      end
   end

   // bus level: three flops, change taken when last two agree
   always_ff @(posedge i_clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         bus_lvl <= 1'b1;
      end
      else
      begin
         s1 <= i_bus_bit;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            bus_lvl <= s3;
      end
   end

   wire busy = (state == CBIM_SEND);
   wire is_id = (i_addr <= `CBIM_OFF_B3);
   wire ctrl_wr = i_wr && (i_addr == `CBIM_OFF_CTRL);
   // receive buffers ignore identifier writes; no writes mid-frame
   wire id_wr = i_wr && is_id && tx_mode && !busy;
   wire go = ctrl_wr && i_wdata[`CBIM_C_GO] && tx_mode && !busy;
   wire take = i_rx.valid && !tx_mode;
   wire clr_new = ctrl_wr && i_wdata[`CBIM_C_CLR];
   wire tick = busy && (div == `CBIM_BIT_DIV);
   wire ide = idb[1][`CBIM_IDE_BIT];
   // recessive out but dominant seen: a smaller identifier won
   wire lose = tick && o_tx_bit && !bus_lvl;
   wire fin = tick && !lose && (cnt == last);

   // receive store layout per format
   assign rx_val[0] = i_rx.ide ? i_rx.id[28:21] : i_rx.id[10:3];
   assign rx_val[1] = i_rx.ide ?
      {i_rx.id[20:18], i_rx.srr, 1'b1, i_rx.id[17:15]} :
      {i_rx.id[2:0], i_rx.rtr, 1'b0, 3'h0};
   assign rx_val[2] = i_rx.id[14:7];
   assign rx_val[3] = {i_rx.id[6:0], i_rx.rtr};

   // identifier bytes live in plain storage with no reset
   generate
      for (genvar k = 0; k < 4; k++)
      begin : g_byte
         logic [7:0] q;
         // standard frames leave bytes two and three untouched
         wire rx_en = take && (i_rx.ide || (k < 2));
         wire wr_en = id_wr && (i_addr[1:0] == 2'(k));
         always_ff @(posedge i_clock)
         begin
            if (rx_en)
               q <= rx_val[k];
            else if (wr_en)
               q <= i_wdata;
         end
         assign idb[k] = q;
      end
   endgenerate

   assign stat_byte = {4'h0, rx_new, done_f, lost_f, busy};
   assign next_rdata = is_id ? idb[i_addr[1:0]] :
      (i_addr == `CBIM_OFF_CTRL) ? {7'h00, tx_mode} :
      (i_addr == `CBIM_OFF_STAT) ? stat_byte : `CBIM_RST8;

   always_ff @(posedge i_clock or negedge rst_q)
   begin
      if (!rst_q)
         o_rdata <= `CBIM_RST8;
      else if (i_rd)
         o_rdata <= next_rdata;
   end

   // control and sticky status; a set beats a same-cycle clear
   always_ff @(posedge i_clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         tx_mode <= 1'b0;
         lost_f <= 1'b0;
         done_f <= 1'b0;
         rx_new <= 1'b0;
      end
      else
      begin
         if (ctrl_wr && !busy)
            tx_mode <= i_wdata[`CBIM_C_TX];
         if (lose)
            lost_f <= 1'b1;
         else if (go)
            lost_f <= 1'b0;
         if (fin)
            done_f <= 1'b1;
         else if (go)
            done_f <= 1'b0;
         if (take)
            rx_new <= 1'b1;
         else if (clr_new)
            rx_new <= 1'b0;
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         CBIM_IDLE:
            if (go)
               next_state = CBIM_SEND;
         CBIM_SEND:
            if (lose || fin)
               next_state = CBIM_IDLE;
         default:
            next_state = CBIM_IDLE;
      endcase
   end

   // arbitration field sender: byte order equals bus order
   always_ff @(posedge i_clock or negedge rst_q)
   begin
      if (!rst_q)
      begin
         state <= CBIM_IDLE;
         div <= 4'h0;
         cnt <= 5'h00;
         last <= 5'h00;
         sh <= 32'h00000000;
         o_tx_bit <= 1'b1;
         o_tx_active <= 1'b0;
         o_tx_done <= 1'b0;
         o_lost <= 1'b0;
      end
      else
      begin
         state <= next_state;
         o_tx_done <= fin;
         o_lost <= lose;
         if (go)
         begin
            // 32 bits extended, 13 standard, top bit first
            sh <= {idb[0], idb[1], idb[2], idb[3]};
            last <= ide ? `CBIM_EXT_LAST : `CBIM_STD_LAST;
            o_tx_bit <= idb[0][7];
            o_tx_active <= 1'b1;
            cnt <= 5'h00;
            div <= 4'h0;
         end
         else if (busy)
         begin
            div <= tick ? 4'h0 : div + 4'h1;
            if (lose || fin)
            begin
               o_tx_active <= 1'b0;
               o_tx_bit <= 1'b1;
            end
            else if (tick)
            begin
               sh <= {sh[30:0], 1'b0};
               o_tx_bit <= sh[30];
               cnt <= cnt + 5'h01;
            end
         end
      end
   end

   // standard identifiers placed at the top so one compare serves both
   always_ff @(posedge i_clock or negedge rst_q)
   begin
      if (!rst_q)
         o_prio_key <= 29'h00000000;
      else if (ide)
         o_prio_key <= {idb[0], idb[1][7:5], idb[1][2:0], idb[2], idb[3][7:1]};
      else
         o_prio_key <= {idb[0], idb[1][7:5], `CBIM_STD_PAD};
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!rst_q);

   chk_ext_length:
   assert property (o_tx_done && ide |-> $past(cnt) == `CBIM_EXT_LAST)
      else $error("extended field length wrong");
   chk_std_length:
   assert property (o_tx_done && !ide |-> $past(cnt) == `CBIM_STD_LAST)
      else $error("standard field length wrong");
   chk_first_bit:
   assert property (go |=> o_tx_active && (o_tx_bit == $past(idb[0][7])))
      else $error("first bit not identifier top bit");
   chk_dominant_keeps:
   assert property (busy && !o_tx_bit |=> !o_lost)
      else $error("dominant sender lost arbitration");
   chk_lost_release:
   assert property (lose |=> !o_tx_active && o_tx_bit && o_lost)
      else $error("bus not released after loss");
   chk_ext_mid:
   assert property (take && i_rx.ide |=> idb[2] == $past(i_rx.id[14:7]))
      else $error("extended byte two wrong");
   chk_ext_low:
   assert property (take && i_rx.ide |=> idb[3] == {$past(i_rx.id[6:0]), $past(i_rx.rtr)})
      else $error("extended byte three wrong");
   chk_std_high:
   assert property (take && !i_rx.ide |=> idb[0] == $past(i_rx.id[10:3]))
      else $error("standard byte zero wrong");
   chk_std_flags:
   assert property (take && !i_rx.ide |=>
      idb[1][7:3] == {$past(i_rx.id[2:0]), $past(i_rx.rtr), 1'b0})
      else $error("standard byte one wrong");
   chk_rx_format:
   assert property (take |=> ide == $past(i_rx.ide))
      else $error("format flag not stored");
   chk_tx_format:
   assert property (go |=> last == ($past(ide) ? `CBIM_EXT_LAST : `CBIM_STD_LAST))
      else $error("frame length not chosen by format flag");
   chk_rx_ignores_wr:
   assert property (i_wr && is_id && !tx_mode && !take |=>
      $stable({idb[0], idb[1], idb[2], idb[3]}))
      else $error("receive buffer accepted a write");
   // frame contents stay frozen while the sender walks them
   chk_busy_refuses_wr:
   assert property (busy && i_wr && is_id |=> $stable({idb[0], idb[1], idb[2], idb[3]}))
      else $error("identifier write landed mid-frame");
   chk_rx_new_set:
   assert property (take |=> rx_new)
      else $error("receive status not raised");
   chk_std_keeps_upper:
   assert property (take && !i_rx.ide |=> $stable({idb[2], idb[3]}))
      else $error("standard frame touched unused bytes");
   chk_ext_flags:
   assert property (take && i_rx.ide |=>
      idb[1] == {$past(i_rx.id[20:18]), $past(i_rx.srr), 1'b1, $past(i_rx.id[17:15])})
      else $error("extended byte one wrong");
   chk_bit_holds:
   assert property (busy && !tick |=> $stable(o_tx_bit))
      else $error("bit changed inside its cell");
   chk_idle_recessive:
   assert property (!busy |-> o_tx_bit && !o_tx_active)
      else $error("idle sender not recessive");
   chk_done_pulse:
   assert property (o_tx_done |=> !o_tx_done)
      else $error("done pulse too long");
   chk_lost_pulse:
   assert property (o_lost |=> !o_lost)
      else $error("lost pulse too long");
endmodule

// ==== inc/cbim_cfg.svh ====
/*
 Constants of the CAN buffer identifier map: register offsets, field
 positions, bit counts and reset values. Included by the package and
 the design; assumes one 10 MHz clock.
*/
// Functional notes
// - extended format holds 29-bit identifier, sent most significant bit first.
// - standard format holds 11-bit identifier, sent top bit first.
// - smallest identifier value has highest arbitration priority, both formats.
// - extended byte two carries identifier bits 14 to 7.
// - extended byte three carries identifier bits 6 to 0, then remote flag.
// - standard byte zero carries identifier bits 10 to 3.
// - standard byte one: identifier bits 2 to 0, remote flag, format zero.
// - standard unused bytes two, three and low bits read undefined.
// - remote flag is 0 for data frame, 1 for remote frame.
// - receive buffer stores received remote flag for an answering frame.
// - transmit buffer sends remote flag exactly as software wrote it.
// - receive buffer sets format flag from the received frame.
// - transmit buffer picks standard or extended sending by format flag.
// - format flag is 0 for 11-bit, 1 for 29-bit identifiers.
// - extended bytes zero and one carry bits 28 to 15, substitute and format.
// - identifier contents are undefined after reset.
`ifndef CBIM_CFG_SVH
`define CBIM_CFG_SVH
`define CBIM_OFF_B0 3'h0
`define CBIM_OFF_B3 3'h3
`define CBIM_OFF_CTRL 3'h4
`define CBIM_OFF_STAT 3'h5
`define CBIM_RST8 8'h00
`define CBIM_BIT_DIV 4'hA
`define CBIM_EXT_LAST 5'h1F
`define CBIM_STD_LAST 5'h0C
`define CBIM_IDE_BIT 3
`define CBIM_STD_RTR_BIT 4
`define CBIM_EXT_RTR_BIT 0
`define CBIM_C_TX 0
`define CBIM_C_GO 1
`define CBIM_C_CLR 2
`define CBIM_STD_PAD 18'h00000
`endif

// ==== inc/cbim_pkg.sv ====
/*
 Types of the CAN buffer identifier map.
 Assumes the protocol engine shares the block clock.
*/
`include "cbim_cfg.svh"
package cbim_pkg;
   typedef struct packed {
      logic valid;
      logic ide;
      logic srr;
      logic rtr;
      logic [28:0] id;
   } cbim_rx_hdr_t;
   typedef enum logic {CBIM_IDLE, CBIM_SEND} cbim_state_t;
endpackage

// ==== testbench/cbim_bus_model.sv ====
/*
 Far side of the buffer: protocol engine handing over received headers,
 and a wired-AND bus with one competing node.
 Assumes the buffer's clock; bus level 1 is recessive.
*/
`timescale 1ns/1ps
module cbim_bus_model
   import cbim_pkg::*;
(
   input wire logic i_clock, // block clock
   input wire logic i_tx_bit, // buffer bit out
   input wire logic i_dom, // other node drives dominant
   output cbim_rx_hdr_t o_rx, // header to buffer
   output logic o_bus_bit // bus level
);
   // wired-AND: any dominant bit wins
   assign o_bus_bit = i_tx_bit & ~i_dom;
   initial o_rx = '0;
   task send(input logic ide, input logic rtr, input logic [28:0] id);
      @(posedge i_clock);
      o_rx <= {1'b1, ide, ide, rtr, id};
      @(posedge i_clock);
      // stale fields flipped so nothing can lean on them
      o_rx <= {1'b0, ~ide, ~ide, ~rtr, ~id};
   endtask
endmodule

// ==== testbench/can_buffer_identifier_map_test.sv ====
/*
 Testbench of the buffer identifier map: register reads and writes,
 receive store, extended and standard sending, arbitration loss.
 Assumes the bus model beside it and the constants header.
*/
`timescale 1ns/1ps
`include "cbim_cfg.svh"
module can_buffer_identifier_map_test
   import cbim_pkg::*;
;
   localparam int BITLEN = `CBIM_BIT_DIV + 1;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic dom = 1'b0;
   cbim_rx_hdr_t rx;
   logic bus, tx_bit, tx_active, tx_done, lost;
   logic [7:0] rdata;
   logic [28:0] key;
   int bad_count = 0;
   int check_count = 0;
   always #50 i_clock = ~i_clock;
   cbim_top cbim_top_inst (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_rx(rx), .i_bus_bit(bus),
      .o_rdata(rdata), .o_tx_bit(tx_bit), .o_tx_active(tx_active),
      .o_tx_done(tx_done), .o_lost(lost), .o_prio_key(key));
   cbim_bus_model cbim_bus_model_inst (.i_clock(i_clock), .i_tx_bit(tx_bit),
      .i_dom(dom), .o_rx(rx), .o_bus_bit(bus));
   function automatic logic [31:0] ext(input logic [28:0] id, input logic r);
      return {id[28:18], 2'b11, id[17:0], r};
   endfunction
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task rchk(input string what, input logic [2:0] a, input logic [7:0] m,
      input logic [7:0] exp);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk(what, {24'h0, exp & m}, {24'h0, rdata & m});
   endtask
   task load(input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         wr(i[2:0], v[31 - 8 * i -: 8]);
      repeat (2) @(posedge i_clock);
   endtask
   task wait_flag(input bit want_lost);
      int k;
      k = 0;
      while (((want_lost ? lost : tx_done) !== 1'b1) && k < 3 * BITLEN)
      begin
         @(posedge i_clock);
         #1 k++;
      end
   endtask
   // samples each bit in mid-cell, so a one-cycle slip still passes
   task frame(input int n, input logic [31:0] exp);
      logic [31:0] got;
      got = '0;
      wr(`CBIM_OFF_CTRL, 8'h03);
      repeat (BITLEN / 2) @(posedge i_clock);
      for (int k = 0; k < n; k++)
      begin
         #1 got = {got[30:0], tx_bit};
         if (k < n - 1)
            repeat (BITLEN) @(posedge i_clock);
      end
      chk("sent bits", exp, got);
      wait_flag(1'b0);
      chk("done idle", 32'h3, {30'h0, tx_done, tx_active ^ tx_bit});
      rchk("stat done", `CBIM_OFF_STAT, 8'h07, 8'h04);
   endtask
   task results;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      #(100 * 3000);
      bad_count++;
      results();
   end
   initial
   begin
      logic [31:0] e;
      repeat (4) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      #1 chk("idle bit", 32'h1, {31'h0, tx_bit});
      rchk("ctrl", `CBIM_OFF_CTRL, 8'hFF, 8'h00);
      rchk("unmapped", 3'h6, 8'hFF, 8'h00);
      $display("test reset done");
      e = ext(29'h12345679, 1'b1);
      cbim_bus_model_inst.send(1'b1, 1'b1, 29'h12345679);
      for (int i = 0; i < 4; i++)
         rchk("rx ext byte", i[2:0], 8'hFF, e[31 - 8 * i -: 8]);
      rchk("rx new", `CBIM_OFF_STAT, 8'h08, 8'h08);
      wr(`CBIM_OFF_CTRL, 8'h04);
      rchk("rx new clear", `CBIM_OFF_STAT, 8'h08, 8'h00);
      wr(3'h0, 8'h3C);
      rchk("rx refused", 3'h0, 8'hFF, e[31:24]);
      cbim_bus_model_inst.send(1'b0, 1'b0, 29'h0000015C);
      rchk("rx std b0", 3'h0, 8'hFF, 8'h2B);
      rchk("rx std b1", 3'h1, 8'hF8, 8'h80);
      rchk("rx std b2", 3'h2, 8'hFF, e[15:8]);
      $display("test receive done");
      wr(`CBIM_OFF_CTRL, 8'h01);
      e = ext(29'h0ABCDEF0, 1'b0);
      load(e);
      #1 chk("ext key", 32'h0ABCDEF0, {3'h0, key});
      frame(32, e);
      $display("test extended send done");
      load({11'h5A3, 1'b1, 1'b0, 19'h0});
      #1 chk("std key", {11'h5A3, 18'h0}, {3'h0, key});
      frame(13, {19'h0, 11'h5A3, 1'b1, 1'b0});
      $display("test standard send done");
      dom <= 1'b1;
      load(ext(29'h1FFFFFFF, 1'b1));
      wr(`CBIM_OFF_CTRL, 8'h03);
      wr(3'h0, 8'h00);
      wait_flag(1'b1);
      chk("lost", 32'h1, {31'h0, lost});
      rchk("stat lost", `CBIM_OFF_STAT, 8'h07, 8'h02);
      rchk("busy refused", 3'h0, 8'hFF, 8'hFF);
      dom <= 1'b0;
      $display("test arbitration loss done");
      results();
   end
endmodule
